// *** design/fdo_map.svh ***
// Address map, field layout and reset values of the output port.
// Assumes inclusion by the package and the design modules.
`ifndef FDO_MAP_SVH
`define FDO_MAP_SVH
`define FDO_OFF_OUT_WORD   8'h00
`define FDO_OFF_RANGE      8'h04
`define FDO_OFF_CODE_CH1   8'h10
`define FDO_OFF_CODE_CH4   8'h1c
`define FDO_OFF_LEVEL_CH1  8'h20
`define FDO_OFF_LEVEL_CH4  8'h2c
`define FDO_CHANS          4
`define FDO_CODE_W         12
`define FDO_SEL_LSB        12
`define FDO_SEL_MSB        15
`define FDO_WORD_W         16
`define FDO_FULL_SCALE     32'sd4095
`define FDO_SPAN_5V_MV     32'sd5000
`define FDO_SPAN_10V_MV    32'sd10000
`define FDO_SPAN_20V_MV    32'sd20000
`define FDO_SPAN_16MA_UA   32'sd16000
`define FDO_LOW_5V_MV      32'sd5000
`define FDO_LOW_10V_MV     32'sd10000
`define FDO_LOW_4MA_UA     32'sd4000
`define FDO_RST_CODE       12'h000
`define FDO_RST_WORD       16'hf000
`define FDO_RESP_OKAY      1'b0
`define FDO_RANGE_MSB      2
`define FDO_IDX_MSB        3
`define FDO_IDX_LSB        2
`define FDO_ADDR_MSB       7
`endif

// *** design/fdo_pkg.sv ***
// Types of the four channel output port.
// Assumes fdo_map.svh is on the include path.
`include "fdo_map.svh"
package fdo_pkg;
    typedef enum logic [2:0] {
        FDO_RNG_0_5V   = 3'b000,
        FDO_RNG_0_10V  = 3'b001,
        FDO_RNG_PM5V   = 3'b010,
        FDO_RNG_PM10V  = 3'b011,
        FDO_RNG_4_20MA = 3'b100
    } fdo_range_e;
    typedef enum logic [0:0] {
        FDO_ST_IDLE    = 1'b0,
        FDO_ST_RD_WAIT = 1'b1
    } fdo_state_e;
    typedef enum logic [2:0] {
        FDO_REG_NONE  = 3'b000,
        FDO_REG_OUT   = 3'b001,
        FDO_REG_RANGE = 3'b010,
        FDO_REG_CODE  = 3'b011,
        FDO_REG_LEVEL = 3'b100
    } fdo_reg_e;
    typedef logic [`FDO_CODE_W-1:0] fdo_code_t;
endpackage : fdo_pkg

// *** design/fdo_bank_if.sv ***
// Link between the port control and its channel code bank.
// Assumes one clock domain on hclk.
`include "fdo_map.svh"
interface fdo_bank_if;
    import fdo_pkg::*;
    logic [`FDO_CHANS-1:0]     wr_en;
    fdo_code_t                 wr_code;
    logic [1:0]                rd_idx;
    fdo_code_t                 rd_code;
    fdo_code_t [`FDO_CHANS-1:0] codes;
    modport ctrl (output wr_en, output wr_code, output rd_idx,
                  input rd_code, input codes);
    modport bank (input wr_en, input wr_code, input rd_idx,
                  output rd_code, output codes);
endinterface : fdo_bank_if

// *** design/fdo_chan_bank.sv ***
// Channel code bank: one held code per channel, registered read port.
// Assumes write enables and code arrive from fdo_port on hclk.
`include "fdo_map.svh"
module fdo_chan_bank
    import fdo_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    fdo_bank_if.bank bus
);
    fdo_code_t [`FDO_CHANS-1:0] code_d;
    fdo_code_t [`FDO_CHANS-1:0] code_q;
    fdo_code_t                  rd_d;
    fdo_code_t                  rd_q;

    genvar g;
    generate
        for (g = 0; g < `FDO_CHANS; g++) begin : g_chan
            // Each channel latches on its own enable, else holds
            always_comb begin
                code_d[g] = bus.wr_en[g] ? bus.wr_code : code_q[g];
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    code_q[g] <= `FDO_RST_CODE;
                end else begin
                    code_q[g] <= code_d[g];
                end
            end
        end
    endgenerate

    // Forward a code written in the same cycle
    always_comb begin
        rd_d = bus.wr_en[bus.rd_idx] ? bus.wr_code : code_q[bus.rd_idx];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= `FDO_RST_CODE;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign bus.rd_code = rd_q;
    assign bus.codes   = code_q;
endmodule : fdo_chan_bank

// *** design/fdo_port.sv ***
// Four channel 12-bit analog output port, AHB-Lite slave top level.
// Assumes a single AHB-Lite master, word transfers, hclk at 40 MHz.
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`include "fdo_map.svh"
module fdo_port
    import fdo_pkg::*;
(
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic                         hready,
    input  wire logic [31:0]                  hwdata,
    output logic      [31:0]                  hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    output fdo_code_t [`FDO_CHANS-1:0]        chan_code,
    output fdo_range_e                        range_sel
);
    fdo_bank_if bank_bus ();

    fdo_state_e                st_d,     st_q;
    fdo_reg_e                  reg_d,    reg_q;
    logic                      wr_d,     wr_q;
    logic [`FDO_WORD_W-1:0]    word_d,   word_q;
    fdo_range_e                rng_d,    rng_q;
    logic [31:0]               rdata_d,  rdata_q;
    logic                      ready_d,  ready_q;
    logic                      take;
    logic [3:0]                sel_n;
    logic                      resp_d,   resp_q;
    logic                      wr_out;

    // Map a byte address onto a register kind
    function automatic fdo_reg_e fdo_decode(input logic [7:0] a);
        if (a == `FDO_OFF_OUT_WORD) begin
            return FDO_REG_OUT;
        end else if (a == `FDO_OFF_RANGE) begin
            return FDO_REG_RANGE;
        end else if (a >= `FDO_OFF_CODE_CH1 && a <= `FDO_OFF_CODE_CH4
                     && a[1:0] == 2'b00) begin
            return FDO_REG_CODE;
        end else if (a >= `FDO_OFF_LEVEL_CH1 && a <= `FDO_OFF_LEVEL_CH4
                     && a[1:0] == 2'b00) begin
            return FDO_REG_LEVEL;
        end else begin
            return FDO_REG_NONE;
        end
    endfunction : fdo_decode

    // Signal level of a code: millivolts, or microamps for the loop range
    function automatic logic [31:0] fdo_level(input fdo_code_t c,
                                              input fdo_range_e r);
        logic signed [31:0] x;
        logic signed [31:0] prod;
        logic signed [31:0] quo;
        logic signed [31:0] span;
        logic signed [31:0] low;
        x    = $signed({20'h00000, c});
        span = 32'sd0;
        low  = 32'sd0;
        case (r)
            FDO_RNG_0_5V: begin
                span = `FDO_SPAN_5V_MV;
                low  = 32'sd0;
            end
            FDO_RNG_0_10V: begin
                span = `FDO_SPAN_10V_MV;
                low  = 32'sd0;
            end
            FDO_RNG_PM5V: begin
                span = `FDO_SPAN_10V_MV;
                low  = -`FDO_LOW_5V_MV;
            end
            FDO_RNG_PM10V: begin
                span = `FDO_SPAN_20V_MV;
                low  = -`FDO_LOW_10V_MV;
            end
            FDO_RNG_4_20MA: begin
                span = `FDO_SPAN_16MA_UA;
                low  = `FDO_LOW_4MA_UA;
            end
            default: begin
                span = 32'sd0;
                low  = 32'sd0;
            end
        endcase
        prod = x * span;
        quo  = prod / `FDO_FULL_SCALE;
        return quo + low;
    endfunction : fdo_level

    // Read data of one register kind
    function automatic logic [31:0] fdo_rd_word(
        input fdo_reg_e               k,
        input logic [`FDO_WORD_W-1:0] w,
        input fdo_range_e             r,
        input fdo_code_t              c
    );
        case (k)
            FDO_REG_OUT:   return {16'h0000, w};
            FDO_REG_RANGE: return {29'h00000000, r};
            FDO_REG_CODE:  return {20'h00000, c};
            FDO_REG_LEVEL: return fdo_level(c, r);
            default:       return 32'h00000000;
        endcase
    endfunction : fdo_rd_word

    assign take  = hsel && hready && htrans[1];
    assign sel_n = hwdata[`FDO_SEL_MSB:`FDO_SEL_LSB];
    assign wr_out = wr_q && reg_q == FDO_REG_OUT;

    // Output word write: low select loads, high select holds
    always_comb begin
        bank_bus.wr_en   = '0;
        bank_bus.wr_code = hwdata[`FDO_CODE_W-1:0];
        bank_bus.rd_idx  = haddr[`FDO_IDX_MSB:`FDO_IDX_LSB];
        if (wr_out) begin
            bank_bus.wr_en = ~sel_n;
        end
    end

    // Bus phase tracking and register writes
    always_comb begin
        st_d    = st_q;
        reg_d   = reg_q;
        wr_d    = 1'b0;
        word_d  = word_q;
        rng_d   = rng_q;
        rdata_d = rdata_q;
        ready_d = ready_q;
        if (wr_q) begin
            case (reg_q)
                FDO_REG_OUT:   word_d = hwdata[`FDO_WORD_W-1:0];
                FDO_REG_RANGE: rng_d  = fdo_range_e'(hwdata[`FDO_RANGE_MSB:0]);
                default:       word_d = word_q;
            endcase
        end
        case (st_q)
            FDO_ST_IDLE: begin
                ready_d = 1'b1;
                if (take) begin
                    reg_d = fdo_decode(haddr[`FDO_ADDR_MSB:0]);
                    wr_d  = hwrite;
                    if (!hwrite) begin
                        st_d    = FDO_ST_RD_WAIT;
                        ready_d = 1'b0;
                    end
                end
            end
            FDO_ST_RD_WAIT: begin
                rdata_d = fdo_rd_word(reg_q, word_q, rng_q, bank_bus.rd_code);
                ready_d = 1'b1;
                st_d    = FDO_ST_IDLE;
            end
            default: begin
                st_d    = FDO_ST_IDLE;
                ready_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q    <= FDO_ST_IDLE;
            reg_q   <= FDO_REG_NONE;
            wr_q    <= 1'b0;
            word_q  <= `FDO_RST_WORD;
            rng_q   <= FDO_RNG_0_10V;
            rdata_q <= 32'h00000000;
            ready_q <= 1'b1;
        end else begin
            st_q    <= st_d;
            reg_q   <= reg_d;
            wr_q    <= wr_d;
            word_q  <= word_d;
            rng_q   <= rng_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
        end
    end

    // Every transfer is answered OKAY, from a flop like the other outputs
    always_comb begin
        resp_d = `FDO_RESP_OKAY;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp_q <= `FDO_RESP_OKAY;
        end else begin
            resp_q <= resp_d;
        end
    end

    fdo_chan_bank u_bank (
        .hclk    (hclk),
        .hresetn (hresetn),
        .bus     (bank_bus.bank)
    );

    assign hrdata    = rdata_q;
    assign hreadyout = ready_q;
    assign hresp     = resp_q;
    assign chan_code = bank_bus.codes;
    assign range_sel = rng_q;
endmodule : fdo_port

// *** sim/fdo_chk.sv ***
// Concurrent checks on the output port pins.
// Assumes one hclk domain and a single bus master.
`include "fdo_map.svh"
module fdo_chk
    import fdo_pkg::*;
(
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [2:0]            hsize,
    input wire logic                  hready,
    input wire logic [31:0]           hwdata,
    input wire logic [31:0]           hrdata,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire fdo_code_t [3:0]       chan_code,
    input wire fdo_range_e            range_sel
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       ph_q;
    logic       wr_q;
    logic [7:0] a_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= 1'b0;
            wr_q <= 1'b0;
            a_q  <= 8'h00;
        end else if (hready) begin
            ph_q <= hsel & htrans[1];
            wr_q <= hwrite;
            a_q  <= haddr[7:0];
        end
    end
    wire wo = ph_q & wr_q & hready & (a_q == `FDO_OFF_OUT_WORD);
    wire rc = ph_q & ~wr_q & hready & (a_q[7:4] == 4'h1);
    wire tk = hsel & htrans[1] & hready;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence rd_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    for (genvar i = 0; i < 4; i++) begin : g_ch
        sel_hold_a: assert property (
            wo && hwdata[12+i] |=> $stable(chan_code[i]))
            else $error("held channel changed");
        sel_load_a: assert property (
            wo && !hwdata[12+i] |=> chan_code[i] == $past(hwdata[11:0]))
            else $error("selected channel not loaded");
    end
    all_load_a: assert property (
        wo && hwdata[15:12] == 4'h0 |=> chan_code[0] == chan_code[1]
        && chan_code[1] == chan_code[2] && chan_code[2] == chan_code[3])
        else $error("channels differ after common load");
    idle_hold_a: assert property (
        !wo |=> $stable(chan_code)) else $error("code moved without write");
    rd_wait_a: assert property (tk && !hwrite |=> rd_wait)
        else $error("read wait state wrong");
    wr_ready_a: assert property (tk && hwrite |=> hreadyout)
        else $error("write stalled");
    okay_resp_a: assert property (hresp == 1'b0) else $error("bad hresp");
    code_read_a: assert property (
        rc |-> hrdata == {20'h0, chan_code[a_q[3:2]]})
        else $error("code readback wrong");
    reset_zero_a: assert property (
        $rose(hresetn) |-> chan_code == '0) else $error("codes not cleared");
endmodule : fdo_chk
bind fdo_port fdo_chk i_fdo_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .chan_code(chan_code),
    .range_sel(range_sel));

// *** sim/fdo_host.sv ***
// Host side model: AHB-Lite master writing output words.
// Assumes the one slave's hreadyout comes back as hready.
module fdo_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] idx = 2'h0;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
    endtask : xfer
    task put(input logic [3:0] sel_n, input logic [11:0] code);
        xfer(32'h0, 1'b1, {16'($urandom), sel_n, code});
    endtask : put
    task rot(input logic [11:0] code);
        put(~(4'h1 << idx), code);
        idx = idx + 2'h1;
    endtask : rot
endmodule : fdo_host

// *** sim/four_channel_dac_output_port_tb.sv ***
// Self-checking bench of the four channel output port.
// Assumes fdo_host as master and fdo_chk bound to the port.
module four_channel_dac_output_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import fdo_pkg::*;
    logic             hclk, hresetn, hsel, hwrite, hready, hresp;
    logic [31:0]      haddr, hwdata, hrdata, e;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    fdo_code_t [3:0]  chan_code;
    fdo_range_e       range_sel;
    logic [31:0]      q[$];
    logic [11:0]      m[4];
    logic [15:0]      ow;
    logic             rd_q = 1'b0;
    int               bad_count = 0, n_tests = 0, lv;
    fdo_port i_fdo_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .chan_code(chan_code),
        .range_sel(range_sel));
    fdo_host i_fdo_host (.hclk(hclk), .hready(hready), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));
    task upd(input logic [3:0] s, input logic [11:0] c);
        ow = {s, c};
        for (int i = 0; i < 4; i++) if (!s[i]) m[i] = c;
    endtask : upd
    task wr(input logic [3:0] s, input logic [11:0] c);
        i_fdo_host.put(s, c);
        upd(s, c);
    endtask : wr
    task rd(input logic [31:0] a, input logic [31:0] x);
        q.push_back(x);
        i_fdo_host.xfer(a, 1'b0, 32'h0);
    endtask : rd
    task see(input string nm, input logic [31:0] x, input logic [31:0] s);
        n_tests++;
        if (s !== x) begin
            $display("wrong value %s exp %h seen %h", nm, x, s);
            bad_count++;
        end
    endtask : see
    task chk_all;
        for (int i = 0; i < 4; i++) rd(32'h10 + 4 * i, {20'h0, m[i]});
        rd(32'h0, {16'h0, ow});
        for (int i = 0; i < 4; i++) begin
            see("chan_code", {20'h0, m[i]}, {20'h0, chan_code[i]});
        end
    endtask : chk_all
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge hclk) begin
        if (rd_q && hready === 1'b1) begin
            e = q.pop_front();
            n_tests++;
            if (hrdata !== e) begin
                $display("wrong value hrdata exp %h seen %h", e, hrdata);
                bad_count++;
            end
            rd_q = 1'b0;
        end
        if (hsel && htrans[1] && hready === 1'b1) rd_q = !hwrite;
    end
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    initial begin
        #2000000;
        bad_count++;
        report_and_stop;
    end
    initial begin
        hresetn = 1'b0;
        void'($urandom(32'hcbaad3ea));
        ow = 16'hf000;
        m = '{default: 12'h0};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        chk_all;
        see("range_sel", 32'h1, {29'h0, range_sel});
        wr(4'hf, 12'h5a5);
        chk_all;
        wr(4'h0, 12'hfff);
        chk_all;
        for (int k = 0; k < 4; k++) begin
            i_fdo_host.rot(12'h100 + 12'(k));
            upd(~(4'h1 << k), 12'h100 + 12'(k));
            chk_all;
        end
        for (int k = 0; k < 24; k++) begin
            wr(4'($urandom), 12'($urandom));
            rd(32'h10 + 4 * (k % 4), {20'h0, m[k % 4]});
        end
        chk_all;
        rd(32'h40, 32'h0);
        for (int r = 0; r < 5; r++) begin
            i_fdo_host.xfer(32'h4, 1'b1, 32'(r));
            case (r)
                0: lv = (int'(m[0]) * 5000) / 4095;
                1: lv = (int'(m[0]) * 10000) / 4095;
                2: lv = (int'(m[0]) * 10000) / 4095 - 5000;
                3: lv = (int'(m[0]) * 20000) / 4095 - 10000;
                default: lv = (int'(m[0]) * 16000) / 4095 + 4000;
            endcase
            rd(32'h4, 32'(r));
            see("range_sel", 32'(r), {29'h0, range_sel});
            rd(32'h20, 32'(lv));
        end
        report_and_stop;
    end
endmodule : four_channel_dac_output_port_tb
